/* File: fspg_guard.sv */
// Access guard for flash self-programming: section decode, locks, halt and busy flag.
`timescale 1ns/1ps
module fspg_guard #(
  parameter int AW = 15,
  parameter int CONC_END = 15'h3800
)
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rstn,
  input  wire logic [AW-1:0]      i_boot_start,
  input  wire logic [AW-1:0]      i_fetch_addr,
  input  wire logic               i_vectors_in_boot,
  input  wire logic               i_store_req,
  input  wire fspg_pkg::fspg_op_t i_store_op,
  input  wire logic [AW-1:0]      i_store_addr,
  input  wire logic [3:0]         i_lock_data,
  input  wire logic               i_load_req,
  input  wire logic [AW-1:0]      i_load_addr,
  input  wire logic               i_flash_done,
  input  wire logic               i_chip_erase,
  output logic                    o_flash_start,
  output fspg_pkg::fspg_op_t      o_flash_op,
  output logic [AW-1:0]           o_flash_addr,
  output logic                    o_store_refused,
  output logic                    o_load_allowed,
  output logic                    o_cpu_halt,
  output logic                    o_conc_read_block,
  output logic                    o_concurrent_busy_flag,
  output logic                    o_irq_disable,
  output logic [1:0]              o_application_lock_field,
  output logic [1:0]              o_boot_lock_field
);

  typedef struct packed {
    fspg_pkg::fspg_state_t st;
    logic                  start;
    fspg_pkg::fspg_op_t    op;
    logic [AW-1:0]         addr;
    logic                  refused;
    logic                  load_ok;
    logic                  halt;
    logic                  block;
    logic                  busy;
    logic                  irq_dis;
    logic [1:0]            app_lock;
    logic [1:0]            boot_lock;
  } fspg_regs_t;

  fspg_regs_t r_q;
  fspg_regs_t r_d;

  // ****************************************************************
  // Section decode helpers.
  // ****************************************************************
  // Boot section is at or above the fuse boundary.
  function automatic logic in_boot(input logic [AW-1:0] a, input logic [AW-1:0] b);
    in_boot = (a >= b);
  endfunction

  // Fixed boundary; the boot start may never fall below it.
  function automatic logic in_conc(input logic [AW-1:0] a);
    in_conc = (a < AW'(CONC_END));
  endfunction

  // Lock modes 2 and 3 forbid stores into the section.
  function automatic logic write_locked(input logic [1:0] f);
    write_locked = (f == fspg_pkg::LOCK_MODE2) || (f == fspg_pkg::LOCK_MODE3);
  endfunction

  // Lock modes 3 and 4 forbid loads issued from code in the other section.
  function automatic logic read_locked(input logic [1:0] f);
    read_locked = (f == fspg_pkg::LOCK_MODE3) || (f == fspg_pkg::LOCK_MODE4);
  endfunction

  logic [AW-1:0] boot_start;
  logic          fetch_boot;
  logic          tgt_boot;
  logic          store_lock;
  logic          load_lock;

  always_comb
  begin
    // Clamp keeps the boot section inside the halting section.
    boot_start = (i_boot_start < AW'(CONC_END)) ? AW'(CONC_END) : i_boot_start;
    fetch_boot = in_boot(i_fetch_addr, boot_start);
    tgt_boot   = in_boot(i_store_addr, boot_start);
    // General lock bits play no part here.
    if (tgt_boot)
      store_lock = write_locked(r_q.boot_lock);
    else
      store_lock = write_locked(r_q.app_lock);
    if (in_boot(i_load_addr, boot_start))
      load_lock = !fetch_boot && read_locked(r_q.boot_lock);
    else
      load_lock = fetch_boot && read_locked(r_q.app_lock);
  end

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb
  begin
    r_d         = r_q;
    r_d.start   = 1'b0;
    r_d.refused = 1'b0;
    // A read-locked load, or a load of the concurrent section while the read block is set, is not returned.
    r_d.load_ok = i_load_req && !load_lock && !(r_q.block && in_conc(i_load_addr));
    if (fetch_boot)
      r_d.irq_dis = !i_vectors_in_boot && read_locked(r_q.boot_lock);
    else
      r_d.irq_dis = i_vectors_in_boot && read_locked(r_q.app_lock);
    case (r_q.st)
      fspg_pkg::FSPG_IDLE:
      begin
        if (i_store_req)
        begin
          if (!fetch_boot)
            r_d.refused = 1'b1;
          else if (i_store_op == fspg_pkg::FSPG_OP_LOCK)
          begin
            // Writing a one keeps a bit; only zeros take effect.
            r_d.app_lock  = r_q.app_lock & i_lock_data[1:0];
            r_d.boot_lock = r_q.boot_lock & i_lock_data[3:2];
          end
          else if (i_store_op == fspg_pkg::FSPG_OP_REENABLE)
          begin
            r_d.busy  = 1'b0;
            r_d.block = 1'b0;
          end
          else if (store_lock)
            r_d.refused = 1'b1;
          else
          begin
            // Any page, boot pages included.
            r_d.start = 1'b1;
            r_d.op    = i_store_op;
            r_d.addr  = i_store_addr;
            if (in_conc(i_store_addr))
            begin
              r_d.st    = fspg_pkg::FSPG_BUSY_CONC;
              r_d.block = 1'b1;
              r_d.busy  = 1'b1;
            end
            else
            begin
              r_d.st   = fspg_pkg::FSPG_BUSY_HALT;
              r_d.halt = 1'b1;
            end
          end
        end
      end
      fspg_pkg::FSPG_BUSY_CONC:
      begin
        // Block and busy flag stay until software re-enables.
        if (i_flash_done)
          r_d.st = fspg_pkg::FSPG_IDLE;
      end
      fspg_pkg::FSPG_BUSY_HALT:
      begin
        if (i_flash_done)
        begin
          r_d.st   = fspg_pkg::FSPG_IDLE;
          r_d.halt = 1'b0;
        end
      end
      default:
        r_d.st = fspg_pkg::FSPG_IDLE;
    endcase
    if (i_chip_erase)
    begin
      r_d.app_lock  = fspg_pkg::LOCK_RESET;
      r_d.boot_lock = fspg_pkg::LOCK_RESET;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      r_q           <= '0;
      r_q.st        <= fspg_pkg::FSPG_IDLE;
      r_q.op        <= fspg_pkg::FSPG_OP_ERASE;
      r_q.app_lock  <= fspg_pkg::LOCK_RESET;
      r_q.boot_lock <= fspg_pkg::LOCK_RESET;
    end
    else
      r_q <= r_d;
  end

  assign o_flash_start            = r_q.start;
  assign o_flash_op               = r_q.op;
  assign o_flash_addr             = r_q.addr;
  assign o_store_refused          = r_q.refused;
  assign o_load_allowed           = r_q.load_ok;
  assign o_cpu_halt               = r_q.halt;
  assign o_conc_read_block        = r_q.block;
  assign o_concurrent_busy_flag   = r_q.busy;
  assign o_irq_disable            = r_q.irq_dis;
  assign o_application_lock_field = r_q.app_lock;
  assign o_boot_lock_field        = r_q.boot_lock;

  // ****************************************************************
  // Assertions: store decisions.
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // A store that the locks must judge: idle, issued from boot code, erase or write.
  logic judged_store;
  assign judged_store = (r_q.st == fspg_pkg::FSPG_IDLE) && i_store_req && fetch_boot &&
                        (i_store_op == fspg_pkg::FSPG_OP_ERASE || i_store_op == fspg_pkg::FSPG_OP_WRITE);

  AST_APP_REFUSE: assert property (
    r_q.st == fspg_pkg::FSPG_IDLE && i_store_req && !fetch_boot
    |=> o_store_refused && !o_flash_start)
    else $error("store from application started");

  AST_FREE_STORE: assert property (
    judged_store && (tgt_boot ? r_q.boot_lock : r_q.app_lock) == fspg_pkg::LOCK_MODE1
    |=> o_flash_start && !o_store_refused)
    else $error("store to unlocked section did not start");

  AST_ANY_PAGE: assert property (
    judged_store && !store_lock
    |=> o_flash_start && o_flash_addr == $past(i_store_addr))
    else $error("permitted store did not latch its page");

  AST_APP_W: assert property (
    judged_store && !tgt_boot && r_q.app_lock == fspg_pkg::LOCK_MODE2
    |=> o_store_refused && !o_flash_start)
    else $error("write to locked application");

  AST_APP_M3: assert property (
    judged_store && !tgt_boot && r_q.app_lock == fspg_pkg::LOCK_MODE3
    |=> o_store_refused && !o_flash_start)
    else $error("store to fully locked application");

  AST_APP_M4: assert property (
    judged_store && !tgt_boot && r_q.app_lock == fspg_pkg::LOCK_MODE4
    |=> o_flash_start && !o_store_refused)
    else $error("read lock stopped an application store");

  AST_BOOT_W: assert property (
    judged_store && tgt_boot && r_q.boot_lock == fspg_pkg::LOCK_MODE2
    |=> o_store_refused && !o_flash_start)
    else $error("write to write locked boot section");

  AST_BOOT_M3: assert property (
    judged_store && tgt_boot && r_q.boot_lock == fspg_pkg::LOCK_MODE3
    |=> o_store_refused && !o_flash_start)
    else $error("store to fully locked boot section");

  // ****************************************************************
  // Assertions: halt, read block and busy flag.
  // ****************************************************************
  AST_HALT_TGT: assert property (
    o_flash_start && !in_conc(o_flash_addr)
    |-> o_cpu_halt)
    else $error("no halt for halting page");

  AST_NO_HALT: assert property (
    o_flash_start && in_conc(o_flash_addr)
    |-> !o_cpu_halt)
    else $error("halt on concurrent page");

  AST_HALT_HOLD: assert property (
    r_q.st == fspg_pkg::FSPG_BUSY_HALT
    |-> o_cpu_halt)
    else $error("halt dropped during operation");

  AST_HALT_END: assert property (
    r_q.st == fspg_pkg::FSPG_BUSY_HALT && i_flash_done
    |=> !o_cpu_halt)
    else $error("halt outlived operation");

  // A load taken in the same cycle as the store request was answered before the block rose.
  AST_BLOCK: assert property (
    o_conc_read_block && i_load_req && in_conc(i_load_addr)
    |=> !o_load_allowed)
    else $error("concurrent read while blocked");

  AST_BLOCK_HOLD: assert property (
    r_q.st == fspg_pkg::FSPG_BUSY_CONC
    |-> o_conc_read_block)
    else $error("read block dropped during operation");

  AST_BUSY: assert property (
    o_conc_read_block == o_concurrent_busy_flag)
    else $error("busy flag mismatch");

  AST_BUSY_HOLD: assert property (
    o_concurrent_busy_flag &&
    !(r_q.st == fspg_pkg::FSPG_IDLE && i_store_req && fetch_boot && i_store_op == fspg_pkg::FSPG_OP_REENABLE)
    |=> o_concurrent_busy_flag)
    else $error("busy flag cleared without re-enable");

  // ****************************************************************
  // Assertions: lock fields, loads and interrupts.
  // ****************************************************************
  AST_LOCK_CLR: assert property (
    i_chip_erase
    |=> o_boot_lock_field == fspg_pkg::LOCK_RESET)
    else $error("chip erase did not clear locks");

  AST_APP_CLR: assert property (
    i_chip_erase
    |=> o_application_lock_field == fspg_pkg::LOCK_RESET)
    else $error("chip erase did not clear application lock");

  AST_LOCK_STICKY: assert property (
    !i_chip_erase
    |=> (o_boot_lock_field & ~$past(o_boot_lock_field)) == 2'h0)
    else $error("lock bit returned to one");

  AST_APP_STICKY: assert property (
    !i_chip_erase
    |=> (o_application_lock_field & ~$past(o_application_lock_field)) == 2'h0)
    else $error("application lock bit returned to one");

  AST_LOAD_APP: assert property (
    i_load_req && fetch_boot && !in_boot(i_load_addr, boot_start) && read_locked(r_q.app_lock)
    |=> !o_load_allowed)
    else $error("boot code read a read locked application");

  AST_LOAD_BOOT: assert property (
    i_load_req && !fetch_boot && in_boot(i_load_addr, boot_start) && read_locked(r_q.boot_lock)
    |=> !o_load_allowed)
    else $error("application code read a read locked boot section");

  AST_LOAD_FREE: assert property (
    i_load_req && !(o_conc_read_block && in_conc(i_load_addr)) &&
    r_q.app_lock == fspg_pkg::LOCK_MODE1 && r_q.boot_lock == fspg_pkg::LOCK_MODE1 |=> o_load_allowed)
    else $error("load refused with both sections unlocked");

  AST_IRQ_APP: assert property (
    !fetch_boot && i_vectors_in_boot && read_locked(r_q.app_lock)
    |=> o_irq_disable)
    else $error("interrupts left on in locked application code");

  AST_IRQ_BOOT: assert property (
    fetch_boot && !i_vectors_in_boot && read_locked(r_q.boot_lock)
    |=> o_irq_disable)
    else $error("interrupts left on in locked boot code");

  COV_CONC: cover property (o_flash_start && o_concurrent_busy_flag);
  COV_HALT: cover property (o_flash_start && o_cpu_halt);
  COV_REFUSE: cover property (o_store_refused);
  COV_REENABLE: cover property ($fell(o_concurrent_busy_flag));
  COV_LOAD_DENIED: cover property (i_load_req && load_lock);

endmodule // fspg_guard

/* File: fspg_pkg.sv */
// Package of constants and types for the flash self-program guard.
package fspg_pkg;

  // ****************************************************************
  // Lock field encodings, 1 means unprogrammed.
  // ****************************************************************
  localparam logic [1:0] LOCK_MODE1  = 2'h3;
  localparam logic [1:0] LOCK_MODE2  = 2'h2;
  localparam logic [1:0] LOCK_MODE3  = 2'h0;
  localparam logic [1:0] LOCK_MODE4  = 2'h1;
  localparam logic [1:0] LOCK_RESET  = 2'h3;

  // ****************************************************************
  // Store operation kinds.
  // ****************************************************************
  typedef enum logic [1:0] {
    FSPG_OP_ERASE,
    FSPG_OP_WRITE,
    FSPG_OP_LOCK,
    FSPG_OP_REENABLE
  } fspg_op_t;

  typedef enum logic [1:0] {
    FSPG_IDLE,
    FSPG_BUSY_CONC,
    FSPG_BUSY_HALT
  } fspg_state_t;

endpackage

/* File: fspg_flash_model.sv */
// Behavioural flash array that answers each started operation with a done pulse.
`timescale 1ns/1ps
module fspg_flash_model
(
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  input  wire logic i_start,
  input  wire logic i_slow,
  output logic      o_done
);
  int cnt;
  // The slow setting keeps an operation running long enough to probe the busy window.
  always @(negedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt = 0;
      o_done = 1'b0;
    end
    else
    begin
      o_done = (cnt == 1);
      if (cnt > 0) cnt--;
      if (i_start && cnt == 0) cnt = i_slow ? 20 : 4;
    end
  end
endmodule // fspg_flash_model

/* File: flash_self_program_guard_test.sv */
// Self-checking testbench for the flash self-program guard.
`timescale 1ns/1ps
module flash_self_program_guard_test;
  localparam logic [14:0] BS = 15'h3c00;
  localparam logic [14:0] PA = 15'h0100;
  localparam logic [14:0] PN = 15'h3900;
  localparam logic [14:0] PB = 15'h3d00;
  localparam logic [14:0] RE = 15'h3800;
  typedef struct packed {
    logic [3:0] lock; logic [14:0] fa; fspg_pkg::fspg_op_t op; logic [14:0] sa;
    logic st; logic [14:0] lf; logic [14:0] la; logic ld;
  } fspg_row_t;
  localparam fspg_pkg::fspg_op_t W = fspg_pkg::FSPG_OP_WRITE;
  localparam fspg_pkg::fspg_op_t E = fspg_pkg::FSPG_OP_ERASE;
  fspg_row_t rows [10] = '{
    '{4'hf, PB, W, PA, 1, PB, PA, 1}, '{4'hf, PA, W, PA, 0, PA, PB, 1},
    '{4'hf, PB, E, PB, 1, PB, PB, 1}, '{4'hf, PB, W, PN, 1, PB, PN, 1},
    '{4'he, PB, W, PA, 0, PB, PA, 1}, '{4'hc, PB, E, PA, 0, PB, PA, 0},
    '{4'hd, PB, W, PA, 1, PB, PA, 0}, '{4'hb, PB, W, PB, 0, PA, PB, 1},
    '{4'h3, PB, W, PB, 0, PA, PB, 0}, '{4'h7, PB, E, PB, 1, PA, PB, 0}};
  logic clk, rstn, vib, sreq, lreq, cer, slow, done, fst, rf, lok, halt, blk, busy, irq, st_s, rf_s, ld_s;
  logic [14:0] bst, fetch, saddr, laddr, fadr;
  logic [3:0] ldat;
  logic [1:0] alk, blk_f;
  fspg_pkg::fspg_op_t sop, fop;
  int mismatches, samples_checked;
  fspg_guard DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_boot_start(bst), .i_fetch_addr(fetch),
    .i_vectors_in_boot(vib), .i_store_req(sreq), .i_store_op(sop), .i_store_addr(saddr),
    .i_lock_data(ldat), .i_load_req(lreq), .i_load_addr(laddr), .i_flash_done(done), .i_chip_erase(cer),
    .o_flash_start(fst), .o_flash_op(fop), .o_flash_addr(fadr), .o_store_refused(rf), .o_load_allowed(lok),
    .o_cpu_halt(halt), .o_conc_read_block(blk), .o_concurrent_busy_flag(busy), .o_irq_disable(irq),
    .o_application_lock_field(alk), .o_boot_lock_field(blk_f));
  fspg_flash_model flash (.i_ref_clk(clk), .i_rstn(rstn), .i_start(fst), .i_slow(slow), .o_done(done));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic store(input fspg_pkg::fspg_op_t op, input logic [14:0] a);
    @(negedge clk) {sop, saddr, sreq} = {op, a, 1'b1};
    @(negedge clk) {sreq, st_s, rf_s} = {1'b0, fst, rf};
    @(negedge clk) {st_s, rf_s} = {st_s | fst, rf_s | rf};
  endtask
  task automatic load(input logic [14:0] a);
    @(negedge clk) {laddr, lreq} = {a, 1'b1};
    @(negedge clk) {lreq, ld_s} = {1'b0, lok};
    @(negedge clk) ld_s |= lok;
  endtask
  task automatic erase();
    @(negedge clk) cer = 1'b1;
    @(negedge clk) cer = 1'b0;
  endtask
  task automatic set_lock(input logic [3:0] d);
    fetch = PB;
    ldat = d;
    store(fspg_pkg::FSPG_OP_LOCK, PA);
  endtask
  task automatic finish_op();
    for (int k = 0; k < 100; k++)
    begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic reenable();
    fetch = PB;
    store(fspg_pkg::FSPG_OP_REENABLE, PA);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // **************************************************************
  // Table walk, then busy window, boundary, locks, interrupts, reset.
  // **************************************************************
  initial
  begin
    {rstn, vib, sreq, lreq, cer, slow, ldat, sop} = '0;
    {bst, fetch, saddr, laddr} = {BS, PB, PA, PA};
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    foreach (rows[i])
    begin
      erase();
      set_lock(rows[i].lock);
      chk("app_lock", alk, rows[i].lock[1:0]);
      chk("boot_lock", blk_f, rows[i].lock[3:2]);
      fetch = rows[i].fa;
      store(rows[i].op, rows[i].sa);
      chk("start", st_s, rows[i].st);
      chk("refused", rf_s, !rows[i].st);
      if (rows[i].st)
      begin
        chk("halt", halt, rows[i].sa >= RE);
        chk("busy", busy, rows[i].sa < RE);
        chk("flash_addr", fadr, rows[i].sa);
        chk("flash_op", fop, rows[i].op);
        finish_op();
        chk("halt_end", halt, 0);
      end
      reenable();
      fetch = rows[i].lf;
      load(rows[i].la);
      chk("load", ld_s, rows[i].ld);
      $display("row %0d finished", i);
    end
    erase();
    slow = 1'b1;
    fetch = PB;
    store(W, PA);
    store(W, PB);
    chk("busy_ignored", {st_s, rf_s}, 0);
    load(PA);
    chk("conc_load", ld_s, 0);
    chk("conc_block", blk, 1);
    finish_op();
    chk("busy_after", busy, 1);
    reenable();
    chk("busy_clear", {busy, blk}, 0);
    slow = 1'b0;
    $display("busy window test finished");
    bst = 15'h3e00;
    store(W, PA);
    chk("moved_boundary", rf_s, 1);
    bst = BS;
    set_lock(4'hc);
    set_lock(4'hf);
    chk("lock_sticky", alk, 2'h0);
    vib = 1'b1;
    fetch = PA;
    repeat (2) @(negedge clk);
    chk("irq_app", irq, 1);
    erase();
    chk("lock_erased", alk, 2'h3);
    set_lock(4'h3);
    vib = 1'b0;
    repeat (2) @(negedge clk);
    chk("irq_boot", irq, 1);
    $display("lock and interrupt tests finished");
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset_out", {alk, blk_f, busy, halt, irq}, 7'h78);
    rstn = 1'b1;
    $display("reset test finished");
    results();
  end
  // The table needs about 170 cycles, so this span is far beyond any healthy run.
  initial
  begin
    #100000;
    mismatches++;
    results();
  end
endmodule // flash_self_program_guard_test
